// *** rtl/lpd_decoder.v ***
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defs.vh"
module lpd_decoder
(
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // payload bytes from the framing layer
  input  wire        frame_start,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  // power sequencer
  input  wire        asleep,
  // outgoing message path
  input  wire        msg_valid,
  output wire        msg_valid_out,
  output wire        ok_to_send,
  output wire        not_ok_to_send,
  // applied configuration
  output reg         cfg_low_power,
  output reg  [1:0]  cfg_feature,
  output reg         cfg_fix_wakeup,
  output reg  [23:0] cfg_rate,
  output reg  [15:0] cfg_search,
  output reg  [15:0] cfg_off,
  output reg  [15:0] cfg_rf_on,
  // default serial settings
  output wire [15:0] uart_baud,
  output wire        spi_subordinate,
  output wire [15:0] spi_max_khz
);

  // ****************************************
  // parser states
  // ****************************************
  localparam ST_IDLE    = 2'b00;
  localparam ST_COLLECT = 2'b01;
  localparam ST_SKIP    = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [5:0]  cnt;
  reg  [7:0]  buf_mem [0:21];
  reg         zero_bad;
  reg         dec_enable;
  reg         fact_reset;
  reg         st_accept;
  reg         st_busy;
  reg         st_bad;
  reg         st_viol;
  wire        last_byte;
  wire        hdr_bad;
  wire        must_zero;
  wire [15:0] w_rate_lo;
  wire [15:0] w_mask;
  wire [15:0] w_search;
  wire [15:0] w_off;
  wire [15:0] w_rf;
  wire [23:0] raw_rate;
  wire        use_fields;
  wire        pfw;
  wire [23:0] rnd_rate;
  wire [23:0] rnd_search;
  wire [23:0] rnd_off;
  reg  [15:0] rf_fix;
  reg  [1:0]  feat_code;
  reg         feat_ok;
  wire        pwr_ok;
  wire        mask_viol;
  wire        rate_viol;
  wire        ev_accept;
  wire        ev_busy;
  wire        ev_bad;
  wire        ev_viol;
  wire        wr;
  wire        rd_hit;

  // ****************************************
  // helpers
  // ****************************************
  function [15:0] be16;
    input [7:0] hi;
    input [7:0] lo;
    begin
      be16 = {hi, lo};
    end
  endfunction

  function is_reg;
    input [11:0] a;
    begin
      is_reg = (a[1:0] == 2'b00) && (a <= `LPD_OFF_IFCFG);
    end
  endfunction

  // ****************************************
  // byte parser
  // ****************************************
  assign last_byte = byte_valid && (cnt == `LPD_MSG_LAST);
  assign hdr_bad   = ((cnt == 6'h00) && (byte_data != `LPD_MSG_ID)) ||
                     ((cnt == 6'h01) && (byte_data != `LPD_MSG_MESSAGE_SUBIDENTIFIER));
  // version, unsupported block and reserved tail
  assign must_zero = (cnt == 6'h04) || ((cnt >= 6'h0e) && (cnt <= 6'h13)) ||
                     (cnt >= 6'h16);

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (frame_start && dec_enable)
          next_state = ST_COLLECT;
      ST_COLLECT:
        if (byte_valid && hdr_bad)
          next_state = ST_SKIP;
        else if (last_byte)
          next_state = ST_IDLE;
      ST_SKIP:
        next_state = ST_SKIP;
      default:
        next_state = ST_IDLE;
    endcase
    // a new frame restarts the parse, or returns it to idle while decoding is disabled
    if (frame_start)
      next_state = dec_enable ? ST_COLLECT : ST_IDLE;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= ST_IDLE;
      cnt      <= 6'h00;
      zero_bad <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (frame_start)
      begin
        cnt      <= 6'h00;
        zero_bad <= 1'b0;
      end
      else if (state == ST_COLLECT && byte_valid)
      begin
        cnt <= cnt + 6'h01;
        if (must_zero && byte_data != 8'h00)
          zero_bad <= 1'b1;
      end
    end
  end

  // memory holds no control state, so it needs no reset
  always @(posedge pclk)
  begin
    if (state == ST_COLLECT && byte_valid && cnt <= `LPD_BUF_LAST)
      buf_mem[cnt[4:0]] <= byte_data;
  end

  // ****************************************
  // field decode
  // ****************************************
  assign w_rate_lo = be16(buf_mem[6], buf_mem[7]);
  assign w_mask    = be16(buf_mem[8], buf_mem[9]);
  assign w_search  = be16(buf_mem[10], buf_mem[11]);
  assign w_off     = be16(buf_mem[12], buf_mem[13]);
  assign w_rf      = be16(buf_mem[20], buf_mem[21]);
  assign raw_rate  = ({16'h0000, buf_mem[5]} << `LPD_RATE_UPPER_SHIFT) |
                     {8'h00, w_rate_lo};
  assign use_fields = w_mask[`LPD_MASK_USE] && !fact_reset;
  assign pfw        = w_mask[`LPD_MASK_PFW];
  assign pwr_ok     = (buf_mem[2] <= 8'h01);
  assign mask_viol  = (w_mask[1] != 1'b0) || (w_mask[15:3] != 13'h0000);
  assign rate_viol  = !pfw && ((raw_rate < `LPD_PDC_RATE_MIN) ||
                      (raw_rate > `LPD_PDC_RATE_MAX));

  always @*
  begin
    feat_ok   = 1'b1;
    feat_code = 2'b00;
    case (buf_mem[3])
      `LPD_FEAT_OFF:  feat_code = 2'b00;
      `LPD_FEAT_LVL1: feat_code = 2'b01;
      `LPD_FEAT_LVL2: feat_code = 2'b10;
      default:        feat_ok   = 1'b0;
    endcase
  end

  // clamp then snap down to the 100 ms grid
  always @*
  begin
    rf_fix = w_rf;
    if (w_rf < `LPD_RFON_MIN)
      rf_fix = `LPD_RFON_MIN;
    else if (w_rf > `LPD_RFON_MAX)
      rf_fix = `LPD_RFON_MAX;
    rf_fix = (rf_fix / `LPD_RFON_STEP) * `LPD_RFON_STEP;
  end

  // ****************************************
  // rounding
  // ****************************************
  lpd_round u_rate
  (
    .value    (raw_rate),
    .round_en (raw_rate != 24'h000000),
    .fine_ok  (1'b1),
    .result   (rnd_rate)
  );

  lpd_round u_search
  (
    .value    ({8'h00, w_search}),
    .round_en (pfw),
    .fine_ok  (1'b0),
    .result   (rnd_search)
  );

  lpd_round u_off
  (
    .value    ({8'h00, w_off}),
    .round_en (pfw),
    .fine_ok  (1'b0),
    .result   (rnd_off)
  );

  // ****************************************
  // apply
  // ****************************************
  assign ev_busy   = last_byte && (state == ST_COLLECT) && asleep;
  assign ev_bad    = last_byte && (state == ST_COLLECT) && !asleep &&
                     !(pwr_ok && feat_ok);
  assign ev_accept = last_byte && (state == ST_COLLECT) && !asleep &&
                     pwr_ok && feat_ok;
  assign ev_viol   = last_byte && (state == ST_COLLECT) && (zero_bad || mask_viol ||
                     rate_viol || (must_zero && byte_data != 8'h00));

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_low_power  <= 1'b0;
      cfg_feature    <= 2'b00;
      cfg_fix_wakeup <= 1'b0;
      cfg_rate       <= `LPD_DEF_RATE;
      cfg_search     <= `LPD_DEF_SEARCH;
      cfg_off        <= `LPD_DEF_OFF;
      cfg_rf_on      <= `LPD_DEF_RFON;
    end
    else if (fact_reset || ev_accept)
    begin
      cfg_low_power  <= !fact_reset && buf_mem[2][0];
      cfg_feature    <= fact_reset ? 2'b00 : feat_code;
      cfg_fix_wakeup <= !fact_reset && pfw;
      cfg_rate       <= fact_reset ? `LPD_DEF_RATE : rnd_rate;
      cfg_search     <= use_fields ? rnd_search[15:0] : `LPD_DEF_SEARCH;
      cfg_off        <= use_fields ? rnd_off[15:0] : `LPD_DEF_OFF;
      cfg_rf_on      <= use_fields ? rf_fix : `LPD_DEF_RFON;
    end
  end

  // ****************************************
  // message gating and notices
  // ****************************************
  lpd_notice u_notice
  (
    .pclk           (pclk),
    .presetn        (presetn),
    .asleep         (asleep),
    .msg_valid      (msg_valid),
    .msg_valid_out  (msg_valid_out),
    .ok_to_send     (ok_to_send),
    .not_ok_to_send (not_ok_to_send)
  );

  assign uart_baud       = `LPD_UART_BAUD;
  assign spi_subordinate = 1'b1;
  assign spi_max_khz     = `LPD_SPI_MAX_KHZ;

  // ****************************************
  // apb registers
  // ****************************************
  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign rd_hit  = is_reg(paddr);
  assign pslverr = psel && penable && !is_reg(paddr);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_enable <= 1'b1;
      fact_reset <= 1'b0;
      st_accept  <= 1'b0;
      st_busy    <= 1'b0;
      st_bad     <= 1'b0;
      st_viol    <= 1'b0;
    end
    else
    begin
      fact_reset <= wr && (paddr == `LPD_OFF_CTRL) && pwdata[1];
      if (wr && paddr == `LPD_OFF_CTRL)
        dec_enable <= pwdata[0];
      // set wins over a write-one clear in the same cycle
      st_accept <= ev_accept |
                   (st_accept & ~(wr && paddr == `LPD_OFF_STATUS && pwdata[1]));
      st_busy   <= ev_busy |
                   (st_busy & ~(wr && paddr == `LPD_OFF_STATUS && pwdata[2]));
      st_bad    <= ev_bad |
                   (st_bad & ~(wr && paddr == `LPD_OFF_STATUS && pwdata[3]));
      st_viol   <= ev_viol |
                   (st_viol & ~(wr && paddr == `LPD_OFF_STATUS && pwdata[4]));
    end
  end

  always @*
  begin
    prdata = 32'h00000000;
    if (psel && rd_hit)
    begin
      case (paddr)
        `LPD_OFF_CTRL:   prdata = {31'h0, dec_enable};
        `LPD_OFF_STATUS: prdata = {27'h0000000, st_viol, st_bad, st_busy,
                                   st_accept, asleep};
        `LPD_OFF_MODE:   prdata = {28'h0000000, cfg_fix_wakeup, cfg_feature,
                                   cfg_low_power};
        `LPD_OFF_RATE:   prdata = {8'h00, cfg_rate};
        `LPD_OFF_SEARCH: prdata = {16'h0000, cfg_search};
        `LPD_OFF_OFFT:   prdata = {16'h0000, cfg_off};
        `LPD_OFF_RFON:   prdata = {16'h0000, cfg_rf_on};
        `LPD_OFF_IFCFG:  prdata = {spi_max_khz, 15'h0000, spi_subordinate} ^
                                  {16'h0000, uart_baud};
        default:         prdata = 32'h00000000;
      endcase
    end
  end

endmodule // lpd_decoder
`default_nettype wire

// *** rtl/lpd_defs.vh ***
`ifndef LPD_DEFS_VH
`define LPD_DEFS_VH
// ****************************************
// message header and layout
// ****************************************
`define LPD_MSG_ID      8'hda
`define LPD_MSG_MESSAGE_SUBIDENTIFIER   8'h06
`define LPD_MSG_LAST    6'h29
`define LPD_BUF_LAST    6'h15
// ****************************************
// field codes
// ****************************************
`define LPD_FEAT_OFF    8'h00
`define LPD_FEAT_LVL1   8'h02
`define LPD_FEAT_LVL2   8'h06
`define LPD_MASK_USE    0
`define LPD_MASK_PFW    2
// ****************************************
// rounding and limits
// ****************************************
`define LPD_FINE_TOP    24'h00001d
`define LPD_RATE_MAX    24'h015180
`define LPD_STEP_FINE   24'h000006
`define LPD_STEP_COARSE 24'h00001e
`define LPD_RATE_UPPER_SHIFT 16
`define LPD_PDC_RATE_MIN 24'h000001
`define LPD_PDC_RATE_MAX 24'h000003
// ****************************************
// reset values and defaults
// ****************************************
`define LPD_DEF_RATE    24'h000001
`define LPD_DEF_SEARCH  16'h0078
`define LPD_DEF_OFF     16'h001e
`define LPD_DEF_RFON    16'h00c8
`define LPD_RFON_MIN    16'h0064
`define LPD_RFON_MAX    16'h0320
`define LPD_RFON_STEP   16'h0064
`define LPD_UART_BAUD   16'h12c0
`define LPD_SPI_MAX_KHZ 16'h1a90
// ****************************************
// register offsets
// ****************************************
`define LPD_OFF_CTRL    12'h000
`define LPD_OFF_STATUS  12'h004
`define LPD_OFF_MODE    12'h008
`define LPD_OFF_RATE    12'h00c
`define LPD_OFF_SEARCH  12'h010
`define LPD_OFF_OFFT    12'h014
`define LPD_OFF_RFON    12'h018
`define LPD_OFF_IFCFG   12'h01c
`define LPD_CTRL_RESET  2'h1
`endif

// *** rtl/lpd_notice.v ***
`timescale 1ns/1ps
`default_nettype none
// gates outgoing messages and flags each sleep transition
module lpd_notice
(
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // power state
  input  wire asleep,
  // message source
  input  wire msg_valid,
  output wire msg_valid_out,
  // notices
  output reg  ok_to_send,
  output reg  not_ok_to_send
);

  reg asleep_q;

  assign msg_valid_out = msg_valid & ~asleep;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      asleep_q       <= 1'b0;
      ok_to_send     <= 1'b0;
      not_ok_to_send <= 1'b0;
    end
    else
    begin
      asleep_q       <= asleep;
      ok_to_send     <= asleep_q & ~asleep;
      not_ok_to_send <= ~asleep_q & asleep;
    end
  end

endmodule // lpd_notice
`default_nettype wire

// *** rtl/lpd_round.v ***
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defs.vh"
// rounds a time up to a whole step; fine steps only below the coarse band
module lpd_round
(
  // value
  input  wire [23:0] value,
  input  wire        round_en,
  input  wire        fine_ok,
  // result
  output reg  [23:0] result
);

  reg [23:0] step;
  reg [23:0] lim;

  always @*
  begin
    step   = `LPD_STEP_COARSE;
    lim    = value;
    result = value;
    if (fine_ok && value <= `LPD_FINE_TOP)
      step = `LPD_STEP_FINE;
    if (fine_ok && value > `LPD_RATE_MAX)
      lim = `LPD_RATE_MAX;
    // ceiling keeps small rates from collapsing to zero
    if (round_en)
      result = ((lim + step - 24'h000001) / step) * step;
  end

endmodule // lpd_round
`default_nettype wire

// *** sim/lpd_decoder_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpd_decoder_props
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // inputs
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        byte_valid,
  input wire logic        asleep,
  input wire logic        msg_valid,
  // outputs
  input wire logic        msg_valid_out,
  input wire logic        ok_to_send,
  input wire logic        not_ok_to_send,
  input wire logic        cfg_low_power,
  input wire logic [23:0] cfg_rate,
  input wire logic [15:0] cfg_rf_on,
  input wire logic [15:0] uart_baud,
  input wire logic        spi_subordinate,
  input wire logic [15:0] spi_max_khz
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel & penable & pwrite;
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  AST_SILENT: assert property (asleep |-> !msg_valid_out)
    else $error("message passed while asleep");
  AST_RESUME: assert property (msg_valid && !asleep |-> msg_valid_out)
    else $error("message lost while awake");
  AST_NOTICE_SLEEP: assert property ($rose(asleep) |-> ##[1:3] s_pulse(not_ok_to_send))
    else $error("no stop notice on sleep");
  AST_NOTICE_WAKE: assert property ($fell(asleep) |-> ##[1:3] s_pulse(ok_to_send))
    else $error("no go notice on wake");
  AST_NOTICE_EXCL: assert property (!(ok_to_send && not_ok_to_send))
    else $error("both notices at once");
  AST_UART_DEF: assert property (uart_baud == 16'h12c0)
    else $error("serial rate not default");
  AST_SPI_DEF: assert property (spi_subordinate && spi_max_khz == 16'h1a90)
    else $error("sync port default wrong");
  property p_rf_grid;
    cfg_rf_on >= 16'h0064 && cfg_rf_on <= 16'h0320 && cfg_rf_on % 16'h0064 == 16'h0000;
  endproperty
  property p_rate_grid;
    cfg_rate <= 24'h015180 && (cfg_rate <= 24'h000001 || (cfg_rate < 24'h00001e ?
      cfg_rate % 24'h000006 == 24'h0 : cfg_rate % 24'h00001e == 24'h0));
  endproperty
  property p_cfg_cause;
    $changed(cfg_rate) |-> $past(byte_valid) || $past(wr) || $past(wr, 2);
  endproperty
  AST_RFON_RANGE: assert property (p_rf_grid)
    else $error("rf on time off grid");
  AST_RATE_GRID: assert property (p_rate_grid)
    else $error("rate off grid");
  AST_CFG_HOLD: assert property (p_cfg_cause)
    else $error("rate moved without cause");
  // the refusal is decided at the last byte, so the next sample must match
  AST_SLEEP_FREEZE: assert property (byte_valid && asleep |=> $stable(cfg_low_power) && $stable(cfg_rate))
    else $error("config changed while asleep");
endmodule // lpd_decoder_props
`default_nettype wire

// *** sim/lpd_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpd_decoder_tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, asleep, msg_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire logic pready, pslverr, frame_start, byte_valid, msg_valid_out, ok_to_send, not_ok_to_send;
  wire logic [31:0] prdata;
  wire logic [7:0] byte_data;
  int err_count = 0;
  int cmp_count = 0;
  int unsigned sd;
  logic [32:0] exq[$];
  logic [1:0] nq[$];
  logic [23:0] rt;
  logic [15:0] rf;
  logic [335:0] m;
  always #5 pclk = ~pclk;
  always @(posedge pclk) msg_valid <= 1'($urandom);
  lpd_host_model host_u (.pclk(pclk), .frame_start(frame_start), .byte_valid(byte_valid),
    .byte_data(byte_data));
  lpd_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .frame_start(frame_start), .byte_valid(byte_valid),
    .byte_data(byte_data), .asleep(asleep), .msg_valid(msg_valid),
    .msg_valid_out(msg_valid_out), .ok_to_send(ok_to_send), .not_ok_to_send(not_ok_to_send),
    .cfg_low_power(), .cfg_feature(), .cfg_fix_wakeup(), .cfg_rate(), .cfg_search(),
    .cfg_off(), .cfg_rf_on(), .uart_baud(), .spi_subordinate(), .spi_max_khz());
  // ****************************************
  // tasks
  // ****************************************
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk("apb read", exq.pop_front(), {pslverr, prdata});
  // a notice with nothing queued is compared against an impossible pattern
  task chk_note(input logic [1:0] g);
    logic [1:0] e;
    e = (nq.size() > 0) ? nq.pop_front() : 2'b11;
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected notice expected %h seen %h", e, g);
    end
  endtask
  always @(posedge pclk)
    if (ok_to_send || not_ok_to_send)
      chk_note({ok_to_send, not_ok_to_send});
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (!pready && i < 16);
    if (!pready)
    begin
      err_count++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task cfg(input logic [3:0] md, input logic [23:0] r, input logic [15:0] s, o, f);
    rd(12'h008, {29'h0, md});
    rd(12'h00c, {9'h0, r});
    rd(12'h010, {17'h0, s});
    rd(12'h014, {17'h0, o});
    rd(12'h018, {17'h0, f});
  endtask
  function automatic logic [23:0] rnd(input logic [23:0] v);
    if (v > 24'h015180)
      v = 24'h015180;
    if (v == 24'h0)
      rnd = 24'h0;
    else if (v < 24'h00001e)
      rnd = (v + 24'h5) / 24'h6 * 24'h6;
    else
      rnd = (v + 24'h1d) / 24'h1e * 24'h1e;
  endfunction
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    {presetn, psel, penable, pwrite, asleep} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sd = $urandom(32'h310f4847);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cfg(4'h0, 24'h1, 16'h78, 16'h1e, 16'hc8);
    rd(12'h01c, {1'b0, 32'h1a9012c1});
    rd(12'h020, {1'b1, 32'h0});
    rd(12'h002, {1'b1, 32'h0});
    host_u.send(host_u.mk(8'h1, 8'h6, 8'h0, 16'ha, 16'h5, 16'h64, 16'h1f, 16'hfa));
    cfg(4'hd, rnd(24'ha), 16'h78, 16'h3c, 16'hc8);
    rt = 24'($urandom_range(3, 1));
    rf = 16'($urandom_range(899, 100));
    host_u.send(host_u.mk(8'h1, 8'h2, 8'h0, rt[15:0], 16'h1, 16'h64, 16'h2d, rf));
    cfg(4'h3, rnd(rt), 16'h64, 16'h2d, rf / 16'h64 * 16'h64);
    host_u.send(host_u.mk(8'h0, 8'h0, 8'h2, 16'h0, 16'h0, 16'h64, 16'h64, 16'h64));
    cfg(4'h0, rnd(24'h020000), 16'h78, 16'h1e, 16'hc8);
    m = host_u.mk(8'h1, 8'h6, 8'h0, 16'h2, 16'h1, 16'h64, 16'h64, 16'hc8);
    m[335:328] = 8'hdb;
    host_u.send(m);
    cfg(4'h0, rnd(24'h020000), 16'h78, 16'h1e, 16'hc8);
    rd(12'h004, {1'b0, 32'h12});
    apb(1'b1, 12'h004, 32'h1f, 33'h0);
    asleep <= 1'b1;
    nq.push_back(2'b01);
    host_u.send(host_u.mk(8'h1, 8'h2, 8'h0, 16'h2, 16'h1, 16'h64, 16'h64, 16'hc8));
    cfg(4'h0, rnd(24'h020000), 16'h78, 16'h1e, 16'hc8);
    rd(12'h004, {1'b0, 32'h5});
    asleep <= 1'b0;
    nq.push_back(2'b10);
    repeat (4) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h3, 33'h0);
    repeat (2) @(posedge pclk);
    cfg(4'h0, 24'h1, 16'h78, 16'h1e, 16'hc8);
    host_u.send(host_u.mk(8'h2, 8'h4, 8'h0, 16'h2, 16'h1, 16'h64, 16'h64, 16'hc8));
    cfg(4'h0, 24'h1, 16'h78, 16'h1e, 16'hc8);
    rd(12'h004, {1'b0, 32'hc});
    apb(1'b1, 12'h000, 32'h0, 33'h0);
    rd(12'h000, {1'b0, 32'h0});
    host_u.send(host_u.mk(8'h1, 8'h2, 8'h0, 16'h2, 16'h1, 16'h64, 16'h64, 16'hc8));
    cfg(4'h0, 24'h1, 16'h78, 16'h1e, 16'hc8);
    chk("notices left", 33'h0, 33'(nq.size()));
    conclude();
  end
endmodule // lpd_decoder_tb_top
bind lpd_decoder lpd_decoder_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .byte_valid(byte_valid), .asleep(asleep),
  .msg_valid(msg_valid), .msg_valid_out(msg_valid_out), .ok_to_send(ok_to_send),
  .not_ok_to_send(not_ok_to_send), .cfg_low_power(cfg_low_power), .cfg_rate(cfg_rate),
  .cfg_rf_on(cfg_rf_on), .uart_baud(uart_baud), .spi_subordinate(spi_subordinate),
  .spi_max_khz(spi_max_khz));
`default_nettype wire

// *** sim/lpd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpd_host_model
(
  // clock
  input  wire logic       pclk,
  // payload link
  output var  logic       frame_start,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data
);
  // ****************************************
  // request builder and sender
  // ****************************************
  initial
  begin
    frame_start = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  function automatic logic [335:0] mk(input logic [7:0] pw, ft, up,
                                      input logic [15:0] lo, um, sr, of, rf);
    mk = {8'hda, 8'h06, pw, ft, 8'h00, up, lo, um, sr, of, 48'h0, rf, 160'h0};
  endfunction
  task automatic send(input logic [335:0] m);
    int i;
    int g;
    @(posedge pclk);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    for (i = 0; i < 42; i++)
    begin
      g = $urandom_range(2, 0);
      // idle data is scrambled so a stale byte cannot pass for a real one
      if (g != 0)
      begin
        byte_valid <= 1'b0;
        byte_data <= ~byte_data;
        repeat (g) @(posedge pclk);
      end
      byte_valid <= 1'b1;
      byte_data <= m[335 - 8 * i -: 8];
      @(posedge pclk);
    end
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
  endtask
endmodule // lpd_host_model
`default_nettype wire
